// ---- rtl/bwd_hold_timer.sv ----
// Saturating counter: done once i_run has held for LIMIT cycles.
// Dropping i_run restarts the count on the next edge.
module bwd_hold_timer #(
  parameter int LIMIT = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  output logic o_done
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] count;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_run) begin
      count <= '0;
    end else if (count != LIM) begin
      count <= count + CW'(1);
    end
  end
  assign o_done = (count == LIM);
endmodule : bwd_hold_timer

// ---- rtl/bwd_pkg.sv ----
// Package for the bus, wake and diagnostic status bank.
// Assumes a single 100 MHz logic clock and synchronous active-high reset.
package bwd_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DOM_TIMEOUT_MS = 20;
  localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TX_ENABLE_TIME_NS = 10000;
  localparam int TX_ENABLE_CYC = (TX_ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Straps latch only after the three-flop synchroniser output has settled
  localparam int STRAP_SETTLE_CYC = 6;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [6:0] ADDR_SECOND_LIN_FAILURE_CODE = 7'h45;
  localparam logic [6:0] ADDR_WAKE_A = 7'h46;
  localparam logic [6:0] ADDR_WAKE_B = 7'h47;
  localparam logic [6:0] ADDR_LEVEL = 7'h48;
  localparam logic [6:0] ADDR_HS_OVL = 7'h54;
  localparam logic [6:0] ADDR_HS_OPEN = 7'h55;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int FAIL_CODE_LSB = 1;
  localparam int WAKE_B_GP_LSB = 4;
  localparam int LEVEL_GP_LSB = 4;
  localparam int LEVEL_CFG_BIT = 6;
  localparam int LEVEL_DEV_BIT = 7;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_TSD = 2'h1;
  localparam logic [1:0] CODE_TXD_DOM = 2'h2;
  localparam logic [1:0] CODE_BUS_DOM = 2'h3;
  typedef enum logic [1:0] {
    LIN_OFF = 2'h0, LIN_WAKE = 2'h1, LIN_NORMAL = 2'h2, LIN_RX_ONLY = 2'h3
  } bwd_lin_mode_type;
  typedef enum logic [1:0] {
    SBC_NORMAL = 2'h0, SBC_STOP = 2'h1, SBC_OTHER = 2'h2
  } bwd_sbc_mode_type;
  typedef enum logic [1:0] {
    GP_OFF = 2'h0, GP_WAKE = 2'h1, GP_LOWSIDE = 2'h2, GP_HIGHSIDE = 2'h3
  } bwd_gp_func_type;
  typedef enum logic [1:0] {
    TX_ON = 2'h0, TX_BLOCKED = 2'h1, TX_RECOVER = 2'h3
  } bwd_tx_state_type;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic lin2;
    logic lin1;
    logic can;
    logic timer;
    logic [2:0] wk;
    logic [1:0] gp;
  } bwd_wake_evt_type;
  typedef struct packed {
    logic [3:0] overload;
    logic [3:0] openload;
  } bwd_hs_evt_type;
  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    logic clr;
  } bwd_host_req_type;
endpackage : bwd_pkg

// ---- rtl/bwd_status_bank.sv ----
// Status bank: second LIN failure, wake sources, input levels, high-side faults.
// Assumes a host read/clear port on i_ref_clk; fault and wake events are
// single-cycle pulses or levels from logic on the same clock.
module bwd_status_bank #(
  parameter int DOM_TIMEOUT = bwd_pkg::DOM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Host register port
  input wire bwd_pkg::bwd_host_req_type i_host,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Second LIN transceiver and CAN transmit enable
  input wire logic i_lin2_txd,
  input wire logic i_lin2_bus,
  input wire bwd_pkg::bwd_lin_mode_type i_lin2_mode,
  input wire logic i_lin2_thermal_shutdown,
  input wire logic i_main_supply_undervoltage,
  input wire logic i_can_supply_undervoltage,
  output logic o_lin2_tx_enable,
  output logic o_can_tx_enable,
  // Wake and fault events
  input wire bwd_pkg::bwd_wake_evt_type i_wake_evt,
  input wire bwd_pkg::bwd_hs_evt_type i_hs_evt,
  // Pins and mode
  input wire logic i_fail_output_test_strap_pin,
  input wire logic i_int_pullup_pin,
  input wire logic [2:0] i_wake_pins,
  input wire logic [1:0] i_gp_pins,
  input wire bwd_pkg::bwd_sbc_mode_type i_sbc_mode,
  input wire bwd_pkg::bwd_gp_func_type [1:0] i_gp_func,
  input wire logic [1:0] i_gp_sel_io,
  input wire logic i_cyclic_active,
  input wire logic i_cyclic_sample
);
  import bwd_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [6:0] pins_sync;
  logic txd_hi, bus_hi, dev_strap, cfg_strap;
  logic [2:0] wk_now;
  logic [1:0] gp_now;
  bwd_sync3 #(.WIDTH(7)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_lin2_txd, i_lin2_bus, i_fail_output_test_strap_pin,
              i_int_pullup_pin, i_wake_pins}),
    .o_level(pins_sync)
  );
  bwd_sync3 #(.WIDTH(2)) u_sync_gp (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(i_gp_pins),
    .o_level(gp_now)
  );
  assign {txd_hi, bus_hi, dev_strap, cfg_strap, wk_now} = pins_sync;

  // ****************************************
  // Dominant timeouts
  // ****************************************
  logic lin2_drives, second_lin_transmit_stuck, second_lin_bus_stuck;
  logic txd_stuck_q, bus_stuck_q, tsd_q;
  assign lin2_drives = (i_lin2_mode == LIN_NORMAL) || (i_lin2_mode == LIN_RX_ONLY);
  bwd_hold_timer #(.LIMIT(DOM_TIMEOUT)) u_txd_dom (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(!txd_hi && lin2_drives),
    .o_done(second_lin_transmit_stuck)
  );
  bwd_hold_timer #(.LIMIT(DOM_TIMEOUT)) u_bus_dom (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(!bus_hi && lin2_drives),
    .o_done(second_lin_bus_stuck)
  );
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      txd_stuck_q <= 1'b0;
      bus_stuck_q <= 1'b0;
      tsd_q <= 1'b0;
    end else begin
      txd_stuck_q <= second_lin_transmit_stuck;
      bus_stuck_q <= second_lin_bus_stuck;
      tsd_q <= i_lin2_thermal_shutdown;
    end
  end

  // ****************************************
  // Transmitter enable
  // ****************************************
  bwd_tx_state_type tx_state, next_tx_state;
  logic lin2_fault, txd_hold_done;
  assign lin2_fault = i_lin2_thermal_shutdown || i_main_supply_undervoltage
                      || second_lin_transmit_stuck || second_lin_bus_stuck;
  bwd_hold_timer #(.LIMIT(TX_ENABLE_CYC)) u_tx_en (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(txd_hi && (tx_state == TX_RECOVER)),
    .o_done(txd_hold_done)
  );
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_ON: begin
        if (lin2_fault) next_tx_state = TX_BLOCKED;
      end
      TX_BLOCKED: begin
        if (!lin2_fault) next_tx_state = TX_RECOVER;
      end
      TX_RECOVER: begin
        if (lin2_fault) next_tx_state = TX_BLOCKED;
        else if (txd_hold_done) next_tx_state = TX_ON;
      end
      default: next_tx_state = TX_BLOCKED;
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_state <= TX_ON;
    end else begin
      tx_state <= next_tx_state;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_lin2_tx_enable <= 1'b0;
      o_can_tx_enable <= 1'b0;
    end else begin
      o_lin2_tx_enable <= (next_tx_state == TX_ON);
      o_can_tx_enable <= !i_can_supply_undervoltage;
    end
  end

  // ****************************************
  // Clear decode
  // ****************************************
  logic clr_fail, clr_wake_a, clr_wake_b, clr_ovl, clr_open;
  always_comb begin
    clr_fail = 1'b0;
    clr_wake_a = 1'b0;
    clr_wake_b = 1'b0;
    clr_ovl = 1'b0;
    clr_open = 1'b0;
    if (!i_host.clr) begin
      clr_fail = 1'b0;
    end else if (i_host.addr == ADDR_SECOND_LIN_FAILURE_CODE) begin
      clr_fail = 1'b1;
    end else if (i_host.addr == ADDR_WAKE_A) begin
      clr_wake_a = 1'b1;
    end else if (i_host.addr == ADDR_WAKE_B) begin
      clr_wake_b = 1'b1;
    end else if (i_host.addr == ADDR_HS_OVL) begin
      clr_ovl = 1'b1;
    end else if (i_host.addr == ADDR_HS_OPEN) begin
      clr_open = 1'b1;
    end
  end

  // ****************************************
  // Failure code
  // ****************************************
  logic [1:0] second_lin_failure_code;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      second_lin_failure_code <= CODE_NONE;
    end else if (i_lin2_thermal_shutdown && !tsd_q) begin
      second_lin_failure_code <= CODE_TSD;
    end else if (second_lin_bus_stuck && !bus_stuck_q) begin
      second_lin_failure_code <= CODE_BUS_DOM;
    end else if (second_lin_transmit_stuck && !txd_stuck_q) begin
      second_lin_failure_code <= CODE_TXD_DOM;
    end else if (clr_fail) begin
      second_lin_failure_code <= CODE_NONE;
    end
  end

  // ****************************************
  // Sticky event flags
  // ****************************************
  logic [7:0] wake_a;
  logic [1:0] wake_b;
  logic [3:0] hs_ovl, hs_open;
  logic [7:0] wake_a_evt;
  assign wake_a_evt = {i_wake_evt.lin2, i_wake_evt.lin1, i_wake_evt.can,
                       i_wake_evt.timer, 1'b0, i_wake_evt.wk};
  // Set takes priority over clear; events count in any mode incl. fail-safe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wake_a <= STATUS_RESET;
    end else begin
      wake_a <= ((clr_wake_a ? 8'h00 : wake_a) | wake_a_evt) & 8'hF7;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wake_b <= 2'h0;
    end else begin
      wake_b <= (clr_wake_b ? 2'h0 : wake_b) | i_wake_evt.gp;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hs_ovl <= 4'h0;
    end else begin
      hs_ovl <= (clr_ovl ? 4'h0 : hs_ovl) | i_hs_evt.overload;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hs_open <= 4'h0;
    end else begin
      hs_open <= (clr_open ? 4'h0 : hs_open) | i_hs_evt.openload;
    end
  end

  // ****************************************
  // Input levels
  // ****************************************
  logic [2:0] strap_cnt;
  logic development_strap_level, pullup_config_strap;
  logic [2:0] wk_lvl;
  logic [1:0] gp_lvl;
  logic gp_mode_ok;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      strap_cnt <= 3'h0;
      development_strap_level <= 1'b0;
      pullup_config_strap <= 1'b0;
    end else if (strap_cnt != 3'(STRAP_SETTLE_CYC)) begin
      strap_cnt <= strap_cnt + 3'h1;
      development_strap_level <= dev_strap;
      pullup_config_strap <= cfg_strap;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wk_lvl <= 3'h0;
    end else if (!i_cyclic_active || i_cyclic_sample) begin
      wk_lvl <= wk_now;
    end
  end
  assign gp_mode_ok = (i_sbc_mode == SBC_NORMAL) || (i_sbc_mode == SBC_STOP);
  generate
    for (genvar g = 0; g < 2; g++) begin : g_gp
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          gp_lvl[g] <= 1'b0;
        end else if (gp_mode_ok && (i_gp_func[g] != GP_OFF)) begin
          gp_lvl[g] <= gp_now[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rd_data <= STATUS_RESET;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_host.rd;
      if (!i_host.rd) begin
        o_rd_data <= o_rd_data;
      end else if (i_host.addr == ADDR_SECOND_LIN_FAILURE_CODE) begin
        o_rd_data <= {5'h00, second_lin_failure_code, 1'b0};
      end else if (i_host.addr == ADDR_WAKE_A) begin
        o_rd_data <= wake_a;
      end else if (i_host.addr == ADDR_WAKE_B) begin
        o_rd_data <= {2'h0, wake_b, 4'h0};
      end else if (i_host.addr == ADDR_LEVEL) begin
        o_rd_data <= {development_strap_level, pullup_config_strap,
                      gp_lvl & i_gp_sel_io, 1'b0, wk_lvl};
      end else if (i_host.addr == ADDR_HS_OVL) begin
        o_rd_data <= {4'h0, hs_ovl};
      end else if (i_host.addr == ADDR_HS_OPEN) begin
        o_rd_data <= {4'h0, hs_open};
      end else begin
        o_rd_data <= STATUS_RESET;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_tsd_code;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_lin2_thermal_shutdown && !tsd_q) |=> second_lin_failure_code == CODE_TSD;
  endproperty
  a_tsd_code: assert property (p_tsd_code) else $error("tsd code not set");
  property p_bus_code;
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(second_lin_bus_stuck) && !(i_lin2_thermal_shutdown && !tsd_q)
      |=> second_lin_failure_code == CODE_BUS_DOM;
  endproperty
  a_bus_code: assert property (p_bus_code) else $error("bus code not set");
  property p_reserved;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_rd_valid |-> (($past(i_host.addr) == ADDR_HS_OVL || $past(i_host.addr) == ADDR_HS_OPEN)
      ? o_rd_data[7:4] == 4'h0 : o_rd_data[3] == 1'b0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_txd_leave;
    @(posedge i_ref_clk) disable iff (i_rst)
    second_lin_transmit_stuck && (txd_hi || !lin2_drives) |=> !second_lin_transmit_stuck;
  endproperty
  a_txd_leave: assert property (p_txd_leave) else $error("txd stuck held");
  property p_bus_leave;
    @(posedge i_ref_clk) disable iff (i_rst)
    second_lin_bus_stuck && (bus_hi || !lin2_drives) |=> !second_lin_bus_stuck;
  endproperty
  a_bus_leave: assert property (p_bus_leave) else $error("bus stuck held");
  property p_tx_block;
    @(posedge i_ref_clk) disable iff (i_rst)
    lin2_fault |=> !o_lin2_tx_enable ##1 !o_lin2_tx_enable;
  endproperty
  a_tx_block: assert property (p_tx_block) else $error("tx on in fault");
  property p_tx_reenable;
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_lin2_tx_enable) |-> $past(i_rst, 2)
      || ($past(tx_state) == TX_RECOVER && $past(txd_hold_done));
  endproperty
  a_tx_reenable: assert property (p_tx_reenable) else $error("early enable");
  property p_wake_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    wake_a[7] && !clr_wake_a |=> wake_a[7];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("flag lost");
  property p_set_wins;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_hs_evt.overload[0] && clr_ovl |=> hs_ovl[0] ##1 (hs_ovl[0] || $past(clr_ovl));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");
  property p_cyclic_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cyclic_active && !i_cyclic_sample |=> $stable(wk_lvl);
  endproperty
  a_cyclic_hold: assert property (p_cyclic_hold) else $error("level moved");
  c_txd_stuck: cover property (@(posedge i_ref_clk) $rose(second_lin_transmit_stuck));
  c_recover: cover property (@(posedge i_ref_clk) $rose(o_lin2_tx_enable));
  c_clash: cover property (@(posedge i_ref_clk) i_wake_evt.lin2 && clr_wake_a);
endmodule : bwd_status_bank

// ---- rtl/bwd_sync3.sv ----
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs asynchronous to i_ref_clk.
module bwd_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Lanes
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  generate
    for (genvar g = 0; g < WIDTH; g++) begin : g_lane
      logic s1, s2, s3;
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          o_level[g] <= 1'b0;
        end else begin
          s1 <= i_async[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            o_level[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule : bwd_sync3

// ---- tb/bwd_host_model.sv ----
// Host model: issues one-cycle read and clear requests to the status bank.
// Assumes it is called from the bench; requests change at the falling edge.
module bwd_host_model
  import bwd_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Register port
  output bwd_pkg::bwd_host_req_type o_host
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Request driver
  // ****************************************
  initial o_host = '{addr: 7'h7F, rd: 1'b0, clr: 1'b0};
  // Idle address shows the inverse of the last one, never a stale value
  task automatic access(input logic [6:0] addr, input logic rd, input logic clr);
    @(negedge i_ref_clk);
    o_host = '{addr: addr, rd: rd, clr: clr};
    @(negedge i_ref_clk);
    o_host = '{addr: ~addr, rd: 1'b0, clr: 1'b0};
  endtask : access
endmodule : bwd_host_model

// ---- tb/testbench.sv ----
// Self-checking bench for the status bank: events, levels, LIN2 failures.
// Assumes the host model drives the register port; reads scored from a queue.
module testbench;
  import bwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DOM = 50;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  bwd_host_req_type i_host;
  logic [7:0] o_rd_data;
  logic o_rd_valid;
  logic o_lin2_tx_enable;
  logic o_can_tx_enable;
  logic txd = 1'b1;
  logic bus = 1'b1;
  logic thermal_shutdown = 1'b0;
  logic can_uv = 1'b0;
  logic main_uv = 1'b0;
  logic dev_pin = 1'b1;
  logic pull_pin = 1'b0;
  bwd_lin_mode_type lin_mode = LIN_NORMAL;
  bwd_wake_evt_type wake_evt = '0;
  bwd_hs_evt_type hs_evt = '0;
  logic [2:0] wk = '0;
  logic [2:0] old_wk;
  logic [1:0] gp = '0;
  logic [1:0] old_gp;
  logic [1:0] sel_io = 2'h3;
  bwd_sbc_mode_type sbc_mode = SBC_NORMAL;
  bwd_gp_func_type [1:0] gp_func = {GP_WAKE, GP_WAKE};
  logic cyc_act = 1'b0;
  logic cyc_smp = 1'b0;
  int n_errors = 0;
  int n_checks = 0;
  logic [14:0] exp_q[$];
  logic [14:0] head;
  logic [6:0] rc_addr[4] = '{ADDR_WAKE_A, ADDR_WAKE_B, ADDR_HS_OVL, ADDR_HS_OPEN};
  bwd_wake_evt_type w1, w2;
  bwd_hs_evt_type h1, h2;
  always #5 i_ref_clk = ~i_ref_clk;
  // ****************************************
  // Instances
  // ****************************************
  bwd_host_model bwd_host_model_inst (.i_ref_clk(i_ref_clk), .o_host(i_host));
  bwd_status_bank #(.DOM_TIMEOUT(DOM)) bwd_status_bank_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_host(i_host),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .i_lin2_txd(txd), .i_lin2_bus(bus), .i_lin2_mode(lin_mode),
    .i_lin2_thermal_shutdown(thermal_shutdown), .i_main_supply_undervoltage(main_uv),
    .i_can_supply_undervoltage(can_uv), .o_lin2_tx_enable(o_lin2_tx_enable),
    .o_can_tx_enable(o_can_tx_enable), .i_wake_evt(wake_evt), .i_hs_evt(hs_evt),
    .i_fail_output_test_strap_pin(dev_pin), .i_int_pullup_pin(pull_pin),
    .i_wake_pins(wk), .i_gp_pins(gp), .i_sbc_mode(sbc_mode), .i_gp_func(gp_func),
    .i_gp_sel_io(sel_io), .i_cyclic_active(cyc_act), .i_cyclic_sample(cyc_smp)
  );
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
    exp_q.push_back({addr, exp});
    bwd_host_model_inst.access(addr, 1'b1, 1'b0);
  endtask : rd
  task automatic cycles(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : cycles
  task automatic pulse(input bwd_wake_evt_type w, input bwd_hs_evt_type h);
    @(negedge i_ref_clk);
    wake_evt = w;
    hs_evt = h;
    @(negedge i_ref_clk);
    wake_evt = '0;
    hs_evt = '0;
  endtask : pulse
  function automatic logic [7:0] ea(input bwd_wake_evt_type w);
    return {w.lin2, w.lin1, w.can, w.timer, 1'b0, w.wk};
  endfunction : ea
  function automatic logic [7:0] eb(input bwd_wake_evt_type w);
    return {2'b00, w.gp, 4'h0};
  endfunction : eb
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // ****************************************
  // Read monitor
  // ****************************************
  always @(negedge i_ref_clk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("Error rd_valid expected 0 seen 1");
      end else begin
        head = exp_q.pop_front();
        check($sformatf("reg_%h", head[14:8]), head[7:0], o_rd_data);
      end
    end
  end
  initial begin
    #200us;
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    give_verdict();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(6));
    cycles(10);
    i_rst = 1'b0;
    cycles(8);
    foreach (rc_addr[i]) rd(rc_addr[i], 8'h00);
    rd(ADDR_SECOND_LIN_FAILURE_CODE, 8'h00);
    rd(ADDR_LEVEL, 8'h80);
    rd(7'h50, 8'h00);
    can_uv = 1'b1;
    cycles(3);
    check("can_tx_en", 8'h00, {7'h00, o_can_tx_enable});
    check("lin2_tx_en", 8'h01, {7'h00, o_lin2_tx_enable});
    can_uv = 1'b0;
    cycles(3);
    check("can_tx_en", 8'h01, {7'h00, o_can_tx_enable});
    $display("Test reset done");
    for (int k = 0; k < 4; k++) begin
      w1 = bwd_wake_evt_type'($urandom);
      w2 = bwd_wake_evt_type'($urandom);
      h1 = bwd_hs_evt_type'($urandom);
      h2 = bwd_hs_evt_type'($urandom);
      pulse(w1, h1);
      cycles(3);
      rd(ADDR_WAKE_A, ea(w1));
      rd(ADDR_WAKE_B, eb(w1));
      rd(ADDR_HS_OVL, {4'h0, h1.overload});
      rd(ADDR_HS_OPEN, {4'h0, h1.openload});
      exp_q.push_back({ADDR_WAKE_A, ea(w1)});
      fork
        bwd_host_model_inst.access(ADDR_WAKE_A, 1'b1, 1'b1);
        pulse(w2, h2);
      join
      rd(ADDR_WAKE_A, ea(w2));
      rd(ADDR_WAKE_B, eb(w1 | w2));
      rd(ADDR_HS_OVL, {4'h0, h1.overload | h2.overload});
      foreach (rc_addr[i]) bwd_host_model_inst.access(rc_addr[i], 1'b0, 1'b1);
      foreach (rc_addr[i]) rd(rc_addr[i], 8'h00);
    end
    $display("Test events done");
    wk = 3'($urandom);
    gp = 2'($urandom);
    cycles(8);
    rd(ADDR_LEVEL, {2'b10, gp, 1'b0, wk});
    cyc_act = 1'b1;
    old_wk = wk;
    wk = ~wk;
    gp = ~gp;
    cycles(8);
    rd(ADDR_LEVEL, {2'b10, gp, 1'b0, old_wk});
    cyc_smp = 1'b1;
    cycles(1);
    cyc_smp = 1'b0;
    cycles(3);
    rd(ADDR_LEVEL, {2'b10, gp, 1'b0, wk});
    cyc_act = 1'b0;
    gp_func = {GP_HIGHSIDE, GP_LOWSIDE};
    gp = ~gp;
    cycles(8);
    rd(ADDR_LEVEL, {2'b10, gp, 1'b0, wk});
    sbc_mode = SBC_OTHER;
    old_gp = gp;
    gp = ~gp;
    cycles(8);
    rd(ADDR_LEVEL, {2'b10, old_gp, 1'b0, wk});
    sel_io = 2'b01;
    cycles(3);
    rd(ADDR_LEVEL, {2'b10, 1'b0, old_gp[0], 1'b0, wk});
    $display("Test levels done");
    txd = 1'b0;
    cycles(DOM + 20);
    rd(ADDR_SECOND_LIN_FAILURE_CODE, {5'h00, CODE_TXD_DOM, 1'b0});
    check("lin2_tx_en", 8'h00, {7'h00, o_lin2_tx_enable});
    txd = 1'b1;
    cycles(TX_ENABLE_CYC - 10);
    check("lin2_tx_en", 8'h00, {7'h00, o_lin2_tx_enable});
    cycles(20);
    check("lin2_tx_en", 8'h01, {7'h00, o_lin2_tx_enable});
    rd(ADDR_SECOND_LIN_FAILURE_CODE, {5'h00, CODE_TXD_DOM, 1'b0});
    bus = 1'b0;
    cycles(DOM + 20);
    rd(ADDR_SECOND_LIN_FAILURE_CODE, {5'h00, CODE_BUS_DOM, 1'b0});
    bus = 1'b1;
    cycles(TX_ENABLE_CYC + 20);
    check("lin2_tx_en", 8'h01, {7'h00, o_lin2_tx_enable});
    bus = 1'b0;
    cycles(DOM + 20);
    check("lin2_tx_en", 8'h00, {7'h00, o_lin2_tx_enable});
    lin_mode = LIN_WAKE;
    cycles(TX_ENABLE_CYC + 20);
    check("lin2_tx_en", 8'h01, {7'h00, o_lin2_tx_enable});
    bus = 1'b1;
    lin_mode = LIN_NORMAL;
    bwd_host_model_inst.access(ADDR_SECOND_LIN_FAILURE_CODE, 1'b0, 1'b1);
    rd(ADDR_SECOND_LIN_FAILURE_CODE, 8'h00);
    thermal_shutdown = 1'b1;
    cycles(5);
    rd(ADDR_SECOND_LIN_FAILURE_CODE, {5'h00, CODE_TSD, 1'b0});
    check("lin2_tx_en", 8'h00, {7'h00, o_lin2_tx_enable});
    thermal_shutdown = 1'b0;
    cycles(TX_ENABLE_CYC + 20);
    check("lin2_tx_en", 8'h01, {7'h00, o_lin2_tx_enable});
    main_uv = 1'b1;
    cycles(3);
    check("lin2_tx_en", 8'h00, {7'h00, o_lin2_tx_enable});
    main_uv = 1'b0;
    cycles(TX_ENABLE_CYC + 20);
    check("lin2_tx_en", 8'h01, {7'h00, o_lin2_tx_enable});
    $display("Test lin2 done");
    dev_pin = 1'b0;
    pull_pin = 1'b1;
    i_rst = 1'b1;
    cycles(2);
    i_rst = 1'b0;
    cycles(8);
    rd(ADDR_SECOND_LIN_FAILURE_CODE, 8'h00);
    rd(ADDR_LEVEL, {2'b01, 2'b00, 1'b0, wk});
    $display("Test restart done");
    cycles(4);
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("Error pending_reads expected 0 seen %0d", exp_q.size());
    end
    give_verdict();
  end
endmodule : testbench
